// *** core/dscp_port_ctrl.sv ***
/*
  test port and two-wire config port sharing pins, plus lock flag and
  output stop control of a pll clock driver.
  assumes: clock inputs from the pll arrive on mclk, test pins come
  straight from pads, pad logic resolves output enables.
*/
// Overview of operation
// R1 - lock flag follows pll lock state
// R2 - gated stop when mode pin or bit59
// R3 - tri-state only when both are zero
// R4 - bit58 picks stop level, complements inverted
// R5 - stop mode covers disable and power down
// R6 - test reset low resets tap asynchronously
// R7 - select high routes pins to test port
// R8 - select low: two-wire, tap forced reset
// R9 - tdo released unless shifting
// R10 - tdo changes on falling test clock
// R11 - tms sampled on rising test clock
// R12 - address pins form two-wire slave address
// R13 - clock pin serves both ports
// R14 - tdi captured on rising test clock
// R15 - bank disabled by pin or config bit
// R16 - power down stops clocks and inputs
// R17 - full sixteen state tap machine
// R18 - upper slave address bits are parameter
`timescale 1ns/1ps
module dscp_port_ctrl #(
  parameter int NBANK = 5,
  parameter logic [dscp_pkg::I2C_HI_W-1:0] I2C_ADDR_HI = 5'h0A
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pllLockIn,
  output logic pllLockedFlag,
  input wire logic outputStopModePin,
  input wire logic bankOutputDisablePin,
  input wire logic powerDownN,
  input wire logic [NBANK-1:0] bankClockIn,
  input wire logic fbClockIn,
  output dscp_pkg::dscp_drive_t [NBANK-1:0] bankClockOut,
  output dscp_pkg::dscp_drive_t feedbackClockOut,
  input wire logic portSelect,
  input wire logic testResetN,
  input wire logic testClock,
  input wire logic tdiSdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic tmsAddr0In,
  input wire logic tdoAddr1In,
  output logic tdoOut,
  output logic tdoOe
);

  // ********************************************************************
  // test clock domain
  // ********************************************************************
  function automatic dscp_pkg::dscp_tap_t tapNext(
    input dscp_pkg::dscp_tap_t s,
    input logic tms
  );
    case (s)
      dscp_pkg::TestLogicReset: tapNext = tms ? dscp_pkg::TestLogicReset
                                              : dscp_pkg::RunTestIdle;
      dscp_pkg::RunTestIdle: tapNext = tms ? dscp_pkg::SelectDr
                                           : dscp_pkg::RunTestIdle;
      dscp_pkg::SelectDr: tapNext = tms ? dscp_pkg::SelectIr
                                        : dscp_pkg::CaptureDr;
      dscp_pkg::CaptureDr: tapNext = tms ? dscp_pkg::Exit1Dr
                                         : dscp_pkg::ShiftDr;
      dscp_pkg::ShiftDr: tapNext = tms ? dscp_pkg::Exit1Dr
                                       : dscp_pkg::ShiftDr;
      dscp_pkg::Exit1Dr: tapNext = tms ? dscp_pkg::UpdateDr
                                       : dscp_pkg::PauseDr;
      dscp_pkg::PauseDr: tapNext = tms ? dscp_pkg::Exit2Dr
                                       : dscp_pkg::PauseDr;
      dscp_pkg::Exit2Dr: tapNext = tms ? dscp_pkg::UpdateDr
                                       : dscp_pkg::ShiftDr;
      dscp_pkg::UpdateDr: tapNext = tms ? dscp_pkg::SelectDr
                                        : dscp_pkg::RunTestIdle;
      dscp_pkg::SelectIr: tapNext = tms ? dscp_pkg::TestLogicReset
                                        : dscp_pkg::CaptureIr;
      dscp_pkg::CaptureIr: tapNext = tms ? dscp_pkg::Exit1Ir
                                         : dscp_pkg::ShiftIr;
      dscp_pkg::ShiftIr: tapNext = tms ? dscp_pkg::Exit1Ir
                                       : dscp_pkg::ShiftIr;
      dscp_pkg::Exit1Ir: tapNext = tms ? dscp_pkg::UpdateIr
                                       : dscp_pkg::PauseIr;
      dscp_pkg::PauseIr: tapNext = tms ? dscp_pkg::Exit2Ir
                                       : dscp_pkg::PauseIr;
      dscp_pkg::Exit2Ir: tapNext = tms ? dscp_pkg::UpdateIr
                                       : dscp_pkg::ShiftIr;
      dscp_pkg::UpdateIr: tapNext = tms ? dscp_pkg::SelectDr
                                        : dscp_pkg::RunTestIdle;
      default: tapNext = dscp_pkg::TestLogicReset;
    endcase
  endfunction

  logic tapRstN;
  dscp_pkg::dscp_tap_t tap_q;
  logic [dscp_pkg::IR_W-1:0] ir_q;
  logic [dscp_pkg::IR_W-1:0] irShift_q;
  logic [dscp_pkg::CFG_W-1:0] drShift_q;
  logic [dscp_pkg::CFG_W-1:0] cfgShadow_q;
  logic bypass_q;
  logic updToggle_q;
  logic tdo_q;
  logic tdoOe_q;
  logic tdoBit;

  // select low or test reset low both hold the tap in reset
  assign tapRstN = testResetN & portSelect; // [R6] [R8] [R7]

  // rising edge: tms steps the machine, pin doubles as test clock
  always_ff @(posedge testClock or negedge tapRstN) begin // [R13]
    if (!tapRstN) begin
      tap_q <= dscp_pkg::TestLogicReset;
    end else begin
      tap_q <= tapNext(tap_q, tmsAddr0In); // [R11] [R17]
    end
  end

  always_ff @(posedge testClock or negedge tapRstN) begin
    if (!tapRstN) begin
      ir_q <= dscp_pkg::INS_BYPASS;
      irShift_q <= dscp_pkg::IR_CAPTURE;
    end else begin
      case (tap_q)
        dscp_pkg::TestLogicReset: ir_q <= dscp_pkg::INS_BYPASS;
        dscp_pkg::CaptureIr: irShift_q <= dscp_pkg::IR_CAPTURE;
        dscp_pkg::ShiftIr: begin
          irShift_q <= {tdiSdaIn, irShift_q[dscp_pkg::IR_W-1:1]}; // [R14]
        end
        dscp_pkg::UpdateIr: ir_q <= irShift_q;
        default: ir_q <= ir_q;
      endcase
    end
  end

  // shadow held still between updates; a tap reset leaves it and cfg
  always_ff @(posedge testClock or negedge rstn) begin
    if (!rstn) begin
      drShift_q <= dscp_pkg::CFG_RST;
      cfgShadow_q <= dscp_pkg::CFG_RST;
      bypass_q <= 1'b0;
      updToggle_q <= 1'b0;
    end else begin
      case (tap_q)
        dscp_pkg::CaptureDr: begin
          drShift_q <= cfgShadow_q;
          bypass_q <= 1'b0;
        end
        dscp_pkg::ShiftDr: begin
          drShift_q <= {tdiSdaIn, drShift_q[dscp_pkg::CFG_W-1:1]}; // [R14]
          bypass_q <= tdiSdaIn; // [R14]
        end
        dscp_pkg::UpdateDr: begin
          if (ir_q == dscp_pkg::INS_CONFIG) begin
            cfgShadow_q <= drShift_q;
            updToggle_q <= ~updToggle_q;
          end
        end
        default: bypass_q <= bypass_q;
      endcase
    end
  end

  always_comb begin
    if (tap_q == dscp_pkg::ShiftIr) begin
      tdoBit = irShift_q[0];
    end else if (ir_q == dscp_pkg::INS_CONFIG) begin
      tdoBit = drShift_q[0];
    end else begin
      tdoBit = bypass_q;
    end
  end

  // falling edge keeps half a clock of hold for the far end
  always_ff @(negedge testClock or negedge tapRstN) begin // [R10]
    if (!tapRstN) begin
      tdo_q <= 1'b0;
      tdoOe_q <= 1'b0;
    end else begin
      tdo_q <= tdoBit; // [R10]
      tdoOe_q <= (tap_q == dscp_pkg::ShiftDr) |
                 (tap_q == dscp_pkg::ShiftIr); // [R9]
    end
  end

  assign tdoOut = tdo_q;
  assign tdoOe = tdoOe_q; // [R9]

  // ********************************************************************
  // synchronisers into mclk
  // ********************************************************************
  logic [dscp_pkg::SYNC_W-1:0] syncIn;
  logic [dscp_pkg::SYNC_W-1:0] sync1_q;
  logic [dscp_pkg::SYNC_W-1:0] sync2_q;
  logic sLock, sMode, sOeDis, sPdN, sSel, sScl, sSda, sA0, sA1, sTog;

  assign syncIn = {pllLockIn, outputStopModePin, bankOutputDisablePin,
                   powerDownN, portSelect, testClock, tdiSdaIn,
                   tmsAddr0In, tdoAddr1In, updToggle_q};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= dscp_pkg::SYNC_RST;
      sync2_q <= dscp_pkg::SYNC_RST;
    end else begin
      sync1_q <= syncIn;
      sync2_q <= sync1_q;
    end
  end

  assign {sLock, sMode, sOeDis, sPdN, sSel, sScl, sSda, sA0, sA1, sTog} =
    sync2_q;

  // ********************************************************************
  // two-wire slave on mclk
  // ********************************************************************
  logic sclPrev_q, sdaPrev_q, togPrev_q;
  logic sclRise, sclFall, startSeen, stopSeen, i2cOn;
  dscp_pkg::dscp_i2c_t i2c_q;
  logic [3:0] bitCnt_q;
  logic [7:0] rxByte_q;
  logic [1:0] kind_q;
  logic [7:0] idx_q;
  logic wrStb;
  logic [7:0] slaveAddr;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclPrev_q <= 1'b0;
      sdaPrev_q <= 1'b0;
      togPrev_q <= 1'b0;
    end else begin
      sclPrev_q <= sScl;
      sdaPrev_q <= sSda;
      togPrev_q <= sTog;
    end
  end

  // power down also holds the serial slave idle
  assign i2cOn = ~sSel & sPdN; // [R8] [R16]
  assign sclRise = sScl & ~sclPrev_q; // [R13]
  assign sclFall = ~sScl & sclPrev_q;
  assign startSeen = sScl & sclPrev_q & sdaPrev_q & ~sSda;
  assign stopSeen = sScl & sclPrev_q & ~sdaPrev_q & sSda;
  assign slaveAddr = {I2C_ADDR_HI, sA1, sA0, dscp_pkg::I2C_WRITE}; // [R12] [R18]

  // only writes are taken; a read address is simply not acknowledged
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      i2c_q <= dscp_pkg::I2cIdle;
      bitCnt_q <= 4'h0;
      rxByte_q <= 8'h00;
      kind_q <= dscp_pkg::KIND_ADDR;
      idx_q <= 8'h00;
      sdaOe <= 1'b0;
    end else if (!i2cOn || stopSeen) begin
      i2c_q <= dscp_pkg::I2cIdle;
      sdaOe <= 1'b0;
    end else if (startSeen) begin
      i2c_q <= dscp_pkg::I2cRecv;
      bitCnt_q <= 4'h0;
      kind_q <= dscp_pkg::KIND_ADDR;
      sdaOe <= 1'b0;
    end else begin
      case (i2c_q)
        dscp_pkg::I2cIdle: sdaOe <= 1'b0;
        dscp_pkg::I2cRecv: begin
          if (sclRise && bitCnt_q != dscp_pkg::BITS_PER_BYTE) begin
            rxByte_q <= {rxByte_q[6:0], sSda};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == dscp_pkg::BITS_PER_BYTE) begin
            bitCnt_q <= 4'h0;
            if (kind_q == dscp_pkg::KIND_ADDR &&
                rxByte_q != slaveAddr) begin // [R12]
              i2c_q <= dscp_pkg::I2cIdle;
            end else begin
              i2c_q <= dscp_pkg::I2cAck;
              sdaOe <= 1'b1;
              if (kind_q == dscp_pkg::KIND_INDEX) begin
                idx_q <= rxByte_q;
              end else if (kind_q == dscp_pkg::KIND_DATA) begin
                idx_q <= idx_q + 8'h01;
              end
            end
          end
        end
        dscp_pkg::I2cAck: begin
          if (sclFall) begin
            sdaOe <= 1'b0;
            i2c_q <= dscp_pkg::I2cRecv;
            if (kind_q != dscp_pkg::KIND_DATA) begin
              kind_q <= kind_q + 2'h1;
            end
          end
        end
        default: i2c_q <= dscp_pkg::I2cIdle;
      endcase
    end
  end

  assign sdaOut = 1'b0;
  assign wrStb = i2cOn & ~stopSeen & ~startSeen &
                 (i2c_q == dscp_pkg::I2cRecv) & sclFall &
                 (bitCnt_q == dscp_pkg::BITS_PER_BYTE) &
                 (kind_q == dscp_pkg::KIND_DATA) &
                 (idx_q < 8'(dscp_pkg::CFG_BYTES));

  // ********************************************************************
  // configuration image
  // ********************************************************************
  logic [dscp_pkg::CFG_W-1:0] cfg_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= dscp_pkg::CFG_RST;
    end else if (sSel && (sTog != togPrev_q)) begin // [R7]
      cfg_q <= cfgShadow_q;
    end else if (wrStb) begin
      cfg_q[{idx_q[3:0], 3'b000} +: 8] <= rxByte_q;
    end
  end

  // ********************************************************************
  // lock flag and output stop control
  // ********************************************************************
  function automatic dscp_pkg::dscp_drive_t stopDrive(
    input logic clk,
    input logic stop,
    input logic gated,
    input logic lvl
  );
    if (!stop) begin
      stopDrive = '{tru: clk, cmp: ~clk, oe: 1'b1};
    end else if (gated) begin
      stopDrive = '{tru: ~lvl, cmp: lvl, oe: 1'b1}; // [R2] [R4]
    end else begin
      stopDrive = '{tru: 1'b0, cmp: 1'b0, oe: 1'b0}; // [R3]
    end
  endfunction

  logic gatedMode;
  logic stopLevel;
  logic [NBANK-1:0] bankStop;

  assign gatedMode = sMode | cfg_q[dscp_pkg::BIT_STOP_GATED]; // [R2] [R3]
  assign stopLevel = cfg_q[dscp_pkg::BIT_STOP_LVL]; // [R4]

  // stopping on mclk keeps the disable synchronous to the clock path
  always_comb begin
    for (int i = 0; i < NBANK; i++) begin
      bankStop[i] = sOeDis | cfg_q[dscp_pkg::BIT_OE_BANK1 - i] // [R15]
                    | ~sPdN; // [R5] [R16]
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bankClockOut <= '0;
      feedbackClockOut <= '0;
      pllLockedFlag <= 1'b0;
    end else begin
      for (int i = 0; i < NBANK; i++) begin
        bankClockOut[i] <= stopDrive(bankClockIn[i], bankStop[i],
                                     gatedMode, stopLevel); // [R5] [R15]
      end
      feedbackClockOut <= stopDrive(fbClockIn, ~sPdN,
                                    gatedMode, stopLevel); // [R5] [R16]
      pllLockedFlag <= sLock; // [R1]
    end
  end

endmodule // dscp_port_ctrl

// *** core/dscp_pkg.sv ***
/*
  shared constants and types of the dual serial config port and the
  output stop control. assumes a 96 bit configuration image.
*/
package dscp_pkg;

  // ********************************************************************
  // configuration image
  // ********************************************************************
  localparam int CFG_W = 96;
  localparam int CFG_BYTES = 12;
  localparam logic [CFG_W-1:0] CFG_RST = '0;
  // bank 1 disable sits at 56, the following banks count downward
  localparam int BIT_OE_BANK1 = 56;
  localparam int BIT_STOP_LVL = 58;
  localparam int BIT_STOP_GATED = 59;

  // ********************************************************************
  // test port
  // ********************************************************************
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] INS_CONFIG = 4'h2;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;

  typedef enum logic [3:0] {
    TestLogicReset, RunTestIdle, SelectDr, CaptureDr, ShiftDr, Exit1Dr,
    PauseDr, Exit2Dr, UpdateDr, SelectIr, CaptureIr, ShiftIr, Exit1Ir,
    PauseIr, Exit2Ir, UpdateIr
  } dscp_tap_t;

  // ********************************************************************
  // two-wire port
  // ********************************************************************
  localparam int I2C_HI_W = 5;
  localparam logic I2C_WRITE = 1'b0;
  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_INDEX = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [1:0] {I2cIdle, I2cRecv, I2cAck} dscp_i2c_t;

  // ********************************************************************
  // outputs and synchroniser
  // ********************************************************************
  typedef struct packed {
    logic tru;
    logic cmp;
    logic oe;
  } dscp_drive_t;

  localparam int SYNC_W = 10;
  localparam logic [SYNC_W-1:0] SYNC_RST = 10'h000;

endpackage

// *** tb/dscp_port_ctrl_sva.sv ***
/* checker of dscp_port_ctrl port behaviour.
   assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
module dscp_port_ctrl_sva #(
  parameter int NBANK = 5
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pllLockIn,
  input wire logic pllLockedFlag,
  input wire logic outputStopModePin,
  input wire logic bankOutputDisablePin,
  input wire logic powerDownN,
  input wire dscp_pkg::dscp_drive_t [NBANK-1:0] bankClockOut,
  input wire dscp_pkg::dscp_drive_t feedbackClockOut,
  input wire logic portSelect,
  input wire logic testResetN,
  input wire logic testClock,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic sdaOe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  chk_lock_follow: assert property (
    $stable(pllLockIn) [*5] |-> pllLockedFlag == pllLockIn)
    else $error("lock flag off");
  chk_tap_release: assert property (
    !(testResetN && portSelect) |-> !tdoOe && !tdoOut)
    else $error("tdo not released in tap reset");
  // tck high phase spans at least one mclk sample
  chk_tdo_hold: assert property (
    disable iff (!rstn || !testResetN || !portSelect)
    testClock && $past(testClock) |-> $stable(tdoOut) && $stable(tdoOe))
    else $error("tdo moved while tck high");
  chk_tdo_fall: assert property (
    disable iff (!rstn || !testResetN || !portSelect)
    $changed(tdoOut) || $rose(tdoOe) |-> !testClock)
    else $error("tdo changed off falling tck");
  chk_fb_gated: assert property (
    (!powerDownN && outputStopModePin) [*6] |->
    feedbackClockOut.oe && feedbackClockOut.tru != feedbackClockOut.cmp)
    else $error("feedback not gated");
  chk_bank_gated: assert property (
    (bankOutputDisablePin && outputStopModePin) [*6] |->
    bankClockOut[0].oe && bankClockOut[0].tru != bankClockOut[0].cmp)
    else $error("bank not gated");
  chk_fb_running: assert property (
    powerDownN [*6] |->
    feedbackClockOut.oe && feedbackClockOut.cmp == !feedbackClockOut.tru)
    else $error("feedback not running");
  chk_sda_quiet: assert property (
    portSelect [*8] |-> !sdaOe)
    else $error("data line driven in test mode");
endmodule // dscp_port_ctrl_sva
bind dscp_port_ctrl dscp_port_ctrl_sva #(.NBANK(NBANK)) u_sva (
  .mclk(mclk), .rstn(rstn), .pllLockIn(pllLockIn),
  .pllLockedFlag(pllLockedFlag), .outputStopModePin(outputStopModePin),
  .bankOutputDisablePin(bankOutputDisablePin), .powerDownN(powerDownN),
  .bankClockOut(bankClockOut), .feedbackClockOut(feedbackClockOut),
  .portSelect(portSelect), .testResetN(testResetN),
  .testClock(testClock), .tdoOut(tdoOut), .tdoOe(tdoOe), .sdaOe(sdaOe));

// *** tb/dscp_ctl_master.sv ***
/* test port and two-wire master model on the shared config pins.
   assumes a pull-up on the data line; the bench calls its tasks. */
`timescale 1ns/1ps
module dscp_ctl_master #(
  parameter logic A1 = 1'b1,
  parameter logic A0 = 1'b0,
  parameter int H = 30
) (
  input wire logic i2cMode,
  input wire logic sdaOe,
  input wire logic sdaOut,
  input wire logic tdoOut,
  output logic testClock,
  output logic tmsAddr0In,
  output logic tdiSdaIn,
  output logic tdoAddr1In
);
  logic tck = 1'b0;
  logic scl = 1'b1;
  logic tms = 1'b1;
  logic sda = 1'b1;
  // tck stands low between frames, scl idles high
  assign testClock = i2cMode ? scl : tck;
  assign tmsAddr0In = i2cMode ? A0 : tms;
  assign tdoAddr1In = A1;
  // wired-and: the device pulls the line to sdaOut while enabled
  assign tdiSdaIn = sda & (sdaOut | ~sdaOe);
  task automatic jtag(input logic m, input logic d, output logic o);
    tms = m;
    sda = d;
    #4 tck = 1'b1; // held across the rising edge
    #6 tck = 1'b0;
    #2 o = tdoOut;
  endtask
  // data moves only well clear of the scl edges
  task automatic i2cBit(input logic b, output logic line);
    sda = b;
    #H scl = 1'b1;
    #H line = tdiSdaIn;
    scl = 1'b0;
    #10;
  endtask
  task automatic i2cByte(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) i2cBit(b[i], x);
    i2cBit(1'b1, ack);
  endtask
  task automatic i2cStart;
    sda = 1'b1;
    scl = 1'b1;
    #H sda = 1'b0;
    #H scl = 1'b0;
    #10;
  endtask
  task automatic i2cStop;
    sda = 1'b0;
    #H scl = 1'b1;
    #H sda = 1'b1;
    #H;
  endtask
endmodule // dscp_ctl_master

// *** tb/dscp_port_ctrl_tb.sv ***
/* self-checking bench of dscp_port_ctrl with the pin master model.
   assumes pll clocks are static levels sampled as data. */
`timescale 1ns/1ps
module dscp_port_ctrl_tb;
  localparam logic [4:0] HI = 5'h13; // arbitrary upper address bits
  logic mclk, rstn, pllLockIn, pllLockedFlag, outputStopModePin;
  logic bankOutputDisablePin, powerDownN, fbClockIn, portSelect;
  logic testResetN, testClock, tdiSdaIn, sdaOut, sdaOe, tmsAddr0In;
  logic tdoAddr1In, tdoOut, tdoOe, o, ack;
  logic [4:0] bankClockIn;
  dscp_pkg::dscp_drive_t [4:0] bankClockOut;
  dscp_pkg::dscp_drive_t feedbackClockOut;
  int errTotal = 0;
  int comparisons = 0;
  dscp_port_ctrl #(.NBANK(5), .I2C_ADDR_HI(HI)) dut (
    .mclk(mclk), .rstn(rstn), .pllLockIn(pllLockIn),
    .pllLockedFlag(pllLockedFlag), .outputStopModePin(outputStopModePin),
    .bankOutputDisablePin(bankOutputDisablePin), .powerDownN(powerDownN),
    .bankClockIn(bankClockIn), .fbClockIn(fbClockIn),
    .bankClockOut(bankClockOut), .feedbackClockOut(feedbackClockOut),
    .portSelect(portSelect), .testResetN(testResetN),
    .testClock(testClock), .tdiSdaIn(tdiSdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .tmsAddr0In(tmsAddr0In), .tdoAddr1In(tdoAddr1In),
    .tdoOut(tdoOut), .tdoOe(tdoOe));
  dscp_ctl_master mst (
    .i2cMode(~portSelect), .sdaOe(sdaOe), .sdaOut(sdaOut), .tdoOut(tdoOut),
    .testClock(testClock), .tmsAddr0In(tmsAddr0In), .tdiSdaIn(tdiSdaIn),
    .tdoAddr1In(tdoAddr1In));
  // ****************
  // helpers
  // ****************
  task automatic chkBit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chkDrv(input string n, input dscp_pkg::dscp_drive_t e,
      input dscp_pkg::dscp_drive_t g);
    comparisons++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic tapIdle;
    repeat (5) mst.jtag(1'b1, 1'b0, o);
    mst.jtag(1'b0, 1'b0, o);
  endtask
  task automatic toDr;
    mst.jtag(1'b1, 1'b0, o);
    mst.jtag(1'b0, 1'b0, o);
    mst.jtag(1'b0, 1'b0, o);
  endtask
  task automatic loadIr(input logic [3:0] ins);
    mst.jtag(1'b1, 1'b0, o);
    toDr();
    chkBit("ir cap0", 1'b1, o);
    for (int i = 0; i < 4; i++) begin
      mst.jtag(i == 3, ins[i], o);
      if (i < 3) chkBit("ir cap", 1'b0, o);
    end
    chkBit("oe exit", 1'b0, tdoOe);
    mst.jtag(1'b1, 1'b0, o);
    mst.jtag(1'b0, 1'b0, o);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic tLock;
    chkBit("lock low", 1'b0, pllLockedFlag);
    pllLockIn = 1'b1;
    settle(5);
    chkBit("lock high", 1'b1, pllLockedFlag);
    pllLockIn = 1'b0;
    settle(5);
    chkBit("lock drop", 1'b0, pllLockedFlag);
  endtask
  task automatic tBypass;
    tapIdle();
    loadIr(dscp_pkg::INS_BYPASS);
    toDr();
    chkBit("byp cap", 1'b0, o);
    chkBit("oe shift", 1'b1, tdoOe);
    mst.jtag(1'b0, 1'b1, o);
    chkBit("byp bit", 1'b1, o);
    settle(1);
    testResetN = 1'b0; // only when a reset is meant
    #1 chkBit("oe trst", 1'b0, tdoOe);
    testResetN = 1'b1;
    mst.jtag(1'b0, 1'b0, o);
    toDr();
    settle(1);
    portSelect = 1'b0;
    #1 chkBit("oe sel", 1'b0, tdoOe);
    portSelect = 1'b1;
  endtask
  task automatic tGate;
    logic [95:0] v;
    for (int l = 0; l < 2; l++) begin
      v = '0;
      v[59] = 1'b1;
      v[58] = l[0];
      tapIdle();
      loadIr(dscp_pkg::INS_CONFIG);
      toDr();
      for (int i = 0; i < 96; i++) mst.jtag(i == 95, v[i], o);
      mst.jtag(1'b1, 1'b0, o);
      mst.jtag(1'b0, 1'b0, o);
      settle(6);
      outputStopModePin = l[0];
      powerDownN = 1'b0;
      settle(6);
      chkDrv("fb gated", {~l[0], l[0], 1'b1}, feedbackClockOut);
      chkDrv("b4 gated", {~l[0], l[0], 1'b1}, bankClockOut[4]);
      powerDownN = 1'b1;
      settle(6);
      chkDrv("b4 run", 3'h3, bankClockOut[4]);
    end
    outputStopModePin = 1'b0;
  endtask
  task automatic tI2c;
    portSelect = 1'b0;
    settle(6);
    for (int k = 0; k < 2; k++) begin
      mst.i2cStart();
      mst.i2cByte({HI, 1'b1, k[0], dscp_pkg::I2C_WRITE}, ack);
      chkBit("addr ack", k[0], ack);
      if (k == 0) begin
        mst.i2cByte(8'h07, ack);
        mst.i2cByte(8'h01, ack);
        chkBit("data ack", 1'b0, ack);
      end
      mst.i2cStop();
    end
    settle(6);
    chkDrv("b0 tri", 3'h0, bankClockOut[0]);
    chkDrv("b1 run", 3'h5, bankClockOut[1]);
    bankOutputDisablePin = 1'b1;
    settle(6);
    chkDrv("b1 tri", 3'h0, bankClockOut[1]);
    outputStopModePin = 1'b1;
    settle(6);
    chkDrv("b1 gated", 3'h5, bankClockOut[1]);
    chkDrv("b0 gated", 3'h5, bankClockOut[0]);
    outputStopModePin = 1'b0;
    bankOutputDisablePin = 1'b0;
    powerDownN = 1'b0;
    settle(6);
    chkDrv("fb tri", 3'h0, feedbackClockOut);
    powerDownN = 1'b1;
    portSelect = 1'b1;
    settle(6);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #100000;
    errTotal++;
    giveVerdict();
  end
  initial begin
    rstn = 1'b0;
    pllLockIn = 1'b0;
    outputStopModePin = 1'b0;
    bankOutputDisablePin = 1'b0;
    powerDownN = 1'b1;
    fbClockIn = 1'b0;
    bankClockIn = 5'h0A;
    portSelect = 1'b1;
    testResetN = 1'b0; // tap reset meant at start
    repeat (3) @(posedge mclk);
    #1 rstn = 1'b1;
    testResetN = 1'b1;
    settle(6);
    tLock();
    tBypass();
    tGate();
    tI2c();
    giveVerdict();
  end
endmodule // dscp_port_ctrl_tb
